// ===== hdl/paired_timer_pkg.sv
package paired_timer_pkg;

  // register byte offsets, one aligned word each
  localparam logic [7:0] OFF_COUNT_LOW = 8'h00;
  localparam logic [7:0] OFF_COUNT_HIGH = 8'h04;
  localparam logic [7:0] OFF_PERIOD_LOW = 8'h08;
  localparam logic [7:0] OFF_PERIOD_HIGH = 8'h0C;
  localparam logic [7:0] OFF_LOW_CTRL = 8'h10;
  localparam logic [7:0] OFF_HIGH_CTRL = 8'h14;
  localparam logic [7:0] OFF_IRQ_CTRL = 8'h18;
  localparam logic [7:0] OFF_IRQ_FLAGS = 8'h1C;

  // timer control field positions
  localparam int BIT_RUN = 15;
  localparam int BIT_IDLE_HALT = 13;
  localparam int BIT_GATE = 6;
  localparam int BIT_PS_HI = 5;
  localparam int BIT_PS_LO = 4;
  localparam int BIT_PAIR = 3;
  localparam int BIT_CLK_SRC = 1;

  // writable bits; the rest read as zero
  localparam logic [15:0] LOW_CTRL_MASK = 16'hA07A;
  localparam logic [15:0] HIGH_CTRL_MASK = 16'hA072;

  // interrupt control field positions
  localparam int BIT_IE_LOW = 0;
  localparam int BIT_IP_LOW = 1;
  localparam int BIT_IE_HIGH = 4;
  localparam int BIT_IP_HIGH = 5;
  localparam logic [15:0] IRQ_CTRL_MASK = 16'h00FF;

  // interrupt flag positions
  localparam int BIT_FLAG_LOW = 0;
  localparam int BIT_FLAG_HIGH = 1;

  // reset values
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] PERIOD_RESET = 16'hFFFF;

  // prescale codes and division ratios
  localparam logic [1:0] PS_DIV1 = 2'b00;
  localparam logic [1:0] PS_DIV8 = 2'b01;
  localparam logic [1:0] PS_DIV64 = 2'b10;
  localparam logic [1:0] PS_DIV256 = 2'b11;
  localparam logic [7:0] LAST_DIV1 = 8'h00;
  localparam logic [7:0] LAST_DIV8 = 8'h07;
  localparam logic [7:0] LAST_DIV64 = 8'h3F;
  localparam logic [7:0] LAST_DIV256 = 8'hFF;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : paired_timer_pkg

// ===== hdl/tick_if.sv
// configuration of one count path and the increment it produces
interface tick_if;
  logic run;
  logic ext_sel;
  logic gate_en;
  logic [1:0] ps_sel;
  logic pin_level;
  logic pin_rise;
  logic tick;

  modport ctrl (output run, output ext_sel, output gate_en, output ps_sel,
                output pin_level, output pin_rise, input tick);
  modport gen (input run, input ext_sel, input gate_en, input ps_sel,
               input pin_level, input pin_rise, output tick);
endinterface : tick_if

// ===== hdl/pin_edge.sv
module pin_edge (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic pin,
  output logic rise
);
  logic last_q;

  // pin is synchronous to aclk, one stage is enough for the edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_q <= 1'b0;
    end else begin
      last_q <= pin;
    end
  end

  assign rise = pin & ~last_q;
endmodule // pin_edge

// ===== hdl/tick_gen.sv
module tick_gen
  import paired_timer_pkg::*;
#(
  parameter int PS_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  tick_if.gen cfg
);
  logic [PS_W-1:0] ps_q;
  logic [PS_W-1:0] last;
  logic in_pulse;

  // prescale ratio decode
  always_comb begin
    unique case (cfg.ps_sel)
      PS_DIV1: last = PS_W'(LAST_DIV1);
      PS_DIV8: last = PS_W'(LAST_DIV8);
      PS_DIV64: last = PS_W'(LAST_DIV64);
      PS_DIV256: last = PS_W'(LAST_DIV256);
    endcase
  end

  // external edges, or every instruction cycle with an optional gate
  always_comb begin
    if (cfg.ext_sel) begin
      in_pulse = cfg.pin_rise;
    end else if (cfg.gate_en) begin
      in_pulse = cfg.pin_level;
    end else begin
      in_pulse = 1'b1;
    end
  end

  // prescaler restarts whenever the timer is stopped
  always_ff @(posedge aclk) begin
    if (!aresetn || !cfg.run) begin
      ps_q <= '0;
    end else if (in_pulse) begin
      ps_q <= (ps_q == last) ? '0 : ps_q + 1'b1;
    end
  end

  assign cfg.tick = cfg.run & in_pulse & (ps_q == last);
endmodule // tick_gen

// ===== hdl/paired_general_timer.sv
// Behaviour
// - timer and gated modes count instruction cycles; counter mode counts pin edges
// - clock source 0 with gate 0 is timer, gate 1 gated, source 1 counter
// - clock source select sits at bit 1, gate enable at bit 6
// - gate bit enables gated accumulation only with internal clock
// - prescale field bits 5:4 divides by 1, 8, 64 or 256
// - run bit 15 starts the 16-bit timer, clearing it stops it
// - idle-halt bit 13 stops counting while the device idles
// - pairing bit 3 of low control joins both timers into 32 bits
// - high timer holds the upper word, low timer the lower word
// - paired mode takes control from low register, idle-halt from high register
// - paired mode uses the high timer's interrupt enable, flag and priority
// - upper period register is the upper word of the 32-bit period
// - count registers read together as the 32-bit count, high over low
// - internal clocking counts at the instruction rate, half the oscillator
//
// Added by the designer: the AXI4-Lite slave port and the address map.
module paired_general_timer
  import paired_timer_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ext_count_pin_low,
  input wire logic ext_count_pin_high,
  input wire logic idle_mode,
  output logic irq_low,
  output logic irq_high,
  output logic [2:0] irq_priority,
  output logic [2:0] upper_irq_priority
);

  // register state
  logic [15:0] count_low_q;
  logic [15:0] count_high_q;
  logic [15:0] period_low_q;
  logic [15:0] period_high_q;
  logic [15:0] low_ctrl_q;
  logic [15:0] high_ctrl_q;
  logic [15:0] irq_ctrl_q;
  logic [1:0] flags_q;

  // bus state
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic aw_got_q;
  logic w_got_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;

  logic wr_fire;
  logic rd_fire;
  logic wide;
  logic tick_low;
  logic tick_high;
  logic match_low;
  logic match_high;
  logic match_wide;
  logic set_low;
  logic set_high;
  logic rise_low;
  logic rise_high;
  logic [31:0] count_wide;
  logic [31:0] rd_word;

  // true when addr selects the register at offset off
  function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [7:0] off);
    return addr[ADDR_W-1:2] == off[ADDR_W-1:2];
  endfunction

  // true for any mapped register
  function automatic logic mapped(input logic [ADDR_W-1:0] addr);
    return hit(addr, OFF_COUNT_LOW) | hit(addr, OFF_COUNT_HIGH) |
           hit(addr, OFF_PERIOD_LOW) | hit(addr, OFF_PERIOD_HIGH) |
           hit(addr, OFF_LOW_CTRL) | hit(addr, OFF_HIGH_CTRL) |
           hit(addr, OFF_IRQ_CTRL) | hit(addr, OFF_IRQ_FLAGS);
  endfunction

  // apply the two low byte strobes to a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
                                          input logic [3:0] strb);
    logic [15:0] res;
    res = old;
    if (strb[0]) begin
      res[7:0] = data[7:0];
    end
    if (strb[1]) begin
      res[15:8] = data[15:8];
    end
    return res;
  endfunction

  // write channel: address and data latched in either order
  assign s_axi_awready = ~aw_got_q & ~bvalid_q;
  assign s_axi_wready = ~w_got_q & ~bvalid_q;
  assign wr_fire = aw_got_q & w_got_q & ~bvalid_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      awaddr_q <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_got_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_got_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_got_q <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_got_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_got_q <= 1'b0;
    end
  end

  // write response, unmapped addresses are refused with slverr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q <= mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // read channel: one outstanding read, answered one cycle after acceptance
  assign s_axi_arready = ~rvalid_q;
  assign rd_fire = s_axi_arvalid & ~rvalid_q;

  always_comb begin
    rd_word = 32'h0000_0000;
    if (hit(s_axi_araddr, OFF_COUNT_LOW)) begin
      rd_word = {16'h0000, count_low_q};
    end else if (hit(s_axi_araddr, OFF_COUNT_HIGH)) begin
      rd_word = {16'h0000, count_high_q};
    end else if (hit(s_axi_araddr, OFF_PERIOD_LOW)) begin
      rd_word = {16'h0000, period_low_q};
    end else if (hit(s_axi_araddr, OFF_PERIOD_HIGH)) begin
      rd_word = {16'h0000, period_high_q};
    end else if (hit(s_axi_araddr, OFF_LOW_CTRL)) begin
      rd_word = {16'h0000, low_ctrl_q};
    end else if (hit(s_axi_araddr, OFF_HIGH_CTRL)) begin
      rd_word = {16'h0000, high_ctrl_q};
    end else if (hit(s_axi_araddr, OFF_IRQ_CTRL)) begin
      rd_word = {16'h0000, irq_ctrl_q};
    end else if (hit(s_axi_araddr, OFF_IRQ_FLAGS)) begin
      rd_word = {30'h0000_0000, flags_q};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= '0;
    end else if (rd_fire) begin
      rvalid_q <= 1'b1;
      rresp_q <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      rdata_q <= rd_word;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;

  // control and period registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_ctrl_q <= CTRL_RESET;
      high_ctrl_q <= CTRL_RESET;
      irq_ctrl_q <= CTRL_RESET;
    end else if (wr_fire) begin
      if (hit(awaddr_q, OFF_LOW_CTRL)) begin
        low_ctrl_q <= merge16(low_ctrl_q, wdata_q, wstrb_q) & LOW_CTRL_MASK;
      end
      if (hit(awaddr_q, OFF_HIGH_CTRL)) begin
        high_ctrl_q <= merge16(high_ctrl_q, wdata_q, wstrb_q) & HIGH_CTRL_MASK;
      end
      if (hit(awaddr_q, OFF_IRQ_CTRL)) begin
        irq_ctrl_q <= merge16(irq_ctrl_q, wdata_q, wstrb_q) & IRQ_CTRL_MASK;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      period_low_q <= PERIOD_RESET;
      period_high_q <= PERIOD_RESET;
    end else if (wr_fire) begin
      if (hit(awaddr_q, OFF_PERIOD_LOW)) begin
        period_low_q <= merge16(period_low_q, wdata_q, wstrb_q);
      end
      if (hit(awaddr_q, OFF_PERIOD_HIGH)) begin
        period_high_q <= merge16(period_high_q, wdata_q, wstrb_q);
      end
    end
  end

  // count paths: low path drives the paired counter, high path only alone
  assign wide = low_ctrl_q[BIT_PAIR];

  tick_if low_cfg ();
  tick_if high_cfg ();

  pin_edge low_edge (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(ext_count_pin_low),
    .rise(rise_low)
  );

  pin_edge high_edge (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(ext_count_pin_high),
    .rise(rise_high)
  );

  // low path config; in paired mode idle-halt comes from the high register
  assign low_cfg.run = low_ctrl_q[BIT_RUN] &
    ~(idle_mode & (wide ? high_ctrl_q[BIT_IDLE_HALT] : low_ctrl_q[BIT_IDLE_HALT]));
  assign low_cfg.ext_sel = low_ctrl_q[BIT_CLK_SRC];
  assign low_cfg.gate_en = low_ctrl_q[BIT_GATE] & ~low_ctrl_q[BIT_CLK_SRC];
  assign low_cfg.ps_sel = low_ctrl_q[BIT_PS_HI:BIT_PS_LO];
  assign low_cfg.pin_level = ext_count_pin_low;
  assign low_cfg.pin_rise = rise_low;

  // high path is held stopped while paired so its own bits do nothing, except idle-halt, which the low path uses
  assign high_cfg.run = ~wide & high_ctrl_q[BIT_RUN] &
    ~(idle_mode & high_ctrl_q[BIT_IDLE_HALT]);
  assign high_cfg.ext_sel = high_ctrl_q[BIT_CLK_SRC];
  assign high_cfg.gate_en = high_ctrl_q[BIT_GATE] & ~high_ctrl_q[BIT_CLK_SRC];
  assign high_cfg.ps_sel = high_ctrl_q[BIT_PS_HI:BIT_PS_LO];
  assign high_cfg.pin_level = ext_count_pin_high;
  assign high_cfg.pin_rise = rise_high;

  tick_gen low_gen (
    .aclk(aclk),
    .aresetn(aresetn),
    .cfg(low_cfg)
  );

  tick_gen high_gen (
    .aclk(aclk),
    .aresetn(aresetn),
    .cfg(high_cfg)
  );

  assign tick_low = low_cfg.tick;
  assign tick_high = high_cfg.tick;

  // period matches
  assign count_wide = {count_high_q, count_low_q};
  assign match_low = count_low_q == period_low_q;
  assign match_high = count_high_q == period_high_q;
  assign match_wide = count_wide == {period_high_q, period_low_q};

  // low word counter; a software write beats a tick in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_low_q <= COUNT_RESET;
    end else if (wr_fire && hit(awaddr_q, OFF_COUNT_LOW)) begin
      count_low_q <= merge16(count_low_q, wdata_q, wstrb_q);
    end else if (tick_low) begin
      if (wide ? match_wide : match_low) begin
        count_low_q <= COUNT_RESET;
      end else begin
        count_low_q <= count_low_q + 16'h0001;
      end
    end
  end

  // high word counter, carried from the low word while paired
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_high_q <= COUNT_RESET;
    end else if (wr_fire && hit(awaddr_q, OFF_COUNT_HIGH)) begin
      count_high_q <= merge16(count_high_q, wdata_q, wstrb_q);
    end else if (wide && tick_low) begin
      if (match_wide) begin
        count_high_q <= COUNT_RESET;
      end else if (count_low_q == 16'hFFFF) begin
        count_high_q <= count_high_q + 16'h0001;
      end
    end else if (!wide && tick_high) begin
      if (match_high) begin
        count_high_q <= COUNT_RESET;
      end else begin
        count_high_q <= count_high_q + 16'h0001;
      end
    end
  end

  // period events; the paired timer reports through the high flag
  assign set_low = ~wide & tick_low & match_low;
  assign set_high = wide ? (tick_low & match_wide) : (tick_high & match_high);

  // flags clear on writing one; a new event in the same cycle wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_q <= 2'b00;
    end else begin
      if (set_low) begin
        flags_q[BIT_FLAG_LOW] <= 1'b1;
      end else if (wr_fire && hit(awaddr_q, OFF_IRQ_FLAGS) && wstrb_q[0] &&
                   wdata_q[BIT_FLAG_LOW]) begin
        flags_q[BIT_FLAG_LOW] <= 1'b0;
      end
      if (set_high) begin
        flags_q[BIT_FLAG_HIGH] <= 1'b1;
      end else if (wr_fire && hit(awaddr_q, OFF_IRQ_FLAGS) && wstrb_q[0] &&
                   wdata_q[BIT_FLAG_HIGH]) begin
        flags_q[BIT_FLAG_HIGH] <= 1'b0;
      end
    end
  end

  // request lines; low enable and priority are ignored while paired
  assign irq_low = ~wide & flags_q[BIT_FLAG_LOW] & irq_ctrl_q[BIT_IE_LOW];
  assign irq_high = flags_q[BIT_FLAG_HIGH] & irq_ctrl_q[BIT_IE_HIGH];
  assign irq_priority = wide ? 3'h0 : irq_ctrl_q[BIT_IP_LOW +: 3];
  assign upper_irq_priority = irq_ctrl_q[BIT_IP_HIGH +: 3];

  // protection bits carry no meaning for this slave
  logic unused_prot;
  assign unused_prot = ^{s_axi_awprot, s_axi_arprot, wstrb_q[3:2], wdata_q[31:16]};

endmodule // paired_general_timer

// ===== dv/ext_pin_model.sv
// far side of the count pins: a burst of rising edges or a held gate level
module ext_pin_model (
  input wire logic aclk,
  input wire logic burst,
  input wire logic level,
  output logic pin
);
  timeunit 1ns;
  timeprecision 100ps;
  logic phase_q = 1'b0;

  // toggles every cycle, so two cycles of burst give one rising edge
  always @(posedge aclk) begin
    phase_q <= burst ? ~phase_q : 1'b0;
  end

  // outside a burst the pin shows the gate level asked for
  assign pin = burst ? phase_q : level;
endmodule // ext_pin_model

// ===== dv/paired_general_timer_asserts.sv
module timer_checker
  import paired_timer_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic irq_low,
  input wire logic irq_high,
  input wire logic [2:0] irq_priority,
  input wire logic [2:0] upper_irq_priority
);
  timeunit 1ns;
  timeprecision 100ps;
  // single domain, so clock and reset are stated once
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // bus handshakes
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  rd_block_a: assert property (s_axi_arready == !s_axi_rvalid) else $error("arready wrong");
  rd_close_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write not answered");
  wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answering");
  wr_close_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer repeated");
  wr_resp_a: assert property (s_axi_bvalid |-> s_axi_bresp == RESP_OKAY
    || s_axi_bresp == RESP_SLVERR) else $error("bad write response");
  rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  // flags are sticky, so an interrupt only drops with a register write
  flag_hold_a: assert property ($fell(irq_high) |-> s_axi_bvalid)
    else $error("high interrupt dropped alone");
  low_hold_a: assert property ($fell(irq_low) |-> s_axi_bvalid)
    else $error("low interrupt dropped alone");
  prio_hold_a: assert property (!$stable({irq_priority, upper_irq_priority})
    |-> s_axi_bvalid) else $error("priority moved alone");

  cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
  cover property ($rose(irq_high));
  cover property ($rose(irq_low));
endmodule // timer_checker

bind paired_general_timer timer_checker u_timer_checker (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .irq_low,
  .irq_high, .irq_priority, .upper_irq_priority);

// ===== dv/testbench.sv
module testbench
  import paired_timer_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [31:0] RUN = 32'h8000, EXT = 32'h0002, PAIR = 32'h0008;
  localparam logic [31:0] HALT = 32'h2000, GATE = 32'h0040;
  logic aclk = 1'b0, aresetn = 1'b0, idle_mode = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, lfsr = 32'h34044116;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic bl = 1'b0, bh = 1'b0, gl = 1'b0, gh = 1'b0;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic ext_count_pin_low, ext_count_pin_high, irq_low, irq_high;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  wire logic [2:0] irq_priority, upper_irq_priority;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  int error_cnt = 0, samples_checked = 0;
  int rt[4] = '{1, 8, 64, 256};

  always #12.5 aclk = ~aclk;

  paired_general_timer u_paired_general_timer (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF),
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready(1'b1),
    .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready(1'b1), .ext_count_pin_low,
    .ext_count_pin_high, .idle_mode, .irq_low, .irq_high, .irq_priority, .upper_irq_priority);
  ext_pin_model u_pin_low (.aclk, .burst(bl), .level(gl), .pin(ext_count_pin_low));
  ext_pin_model u_pin_high (.aclk, .burst(bh), .level(gh), .pin(ext_count_pin_high));

  function automatic logic [31:0] rnd(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input string nm, input logic [33:0] exp, input logic [33:0] got);
    samples_checked++;
    if (exp !== got) begin
      $display("Error %s expected %h seen %h", nm, exp, got);
      error_cnt++;
    end
  endtask

  task automatic stop_test();
    $display("mismatches %0d comparisons %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // master holds each channel until its own ready, then waits for the answer
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    bq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    if (n == 100) begin
      error_cnt++;
      stop_test();
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    rq.push_back({r, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    if (n == 100) begin
      error_cnt++;
      stop_test();
    end
  endtask

  // k rising edges on the count pins, then a few settling cycles
  task automatic pulses(input int k, input logic both);
    bl <= 1'b1;
    bh <= both;
    repeat (2 * k) @(posedge aclk);
    bl <= 1'b0;
    bh <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask

  // answers are judged against the oldest note left by the driver
  always @(posedge aclk) begin
    if (aresetn && s_axi_rvalid === 1'b1) begin
      if (rq.size() > 0) chk("rdata", rq.pop_front(), {s_axi_rresp, s_axi_rdata});
      else chk("unasked read", 34'h0, 34'h1);
    end
    if (aresetn && s_axi_bvalid === 1'b1) begin
      if (bq.size() > 0) chk("bresp", {32'h0, bq.pop_front()}, {32'h0, s_axi_bresp});
      else chk("unasked write", 34'h0, 34'h1);
    end
  end

  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 8; i++) rd(8'(i * 4), (i == 2 || i == 3) ? 32'hFFFF : 32'h0, RESP_OKAY);
    rd(8'h20, 32'h0, RESP_SLVERR);
    wr(8'h20, 32'hFFFF, RESP_SLVERR);
    wr(OFF_LOW_CTRL, 32'hFFFF, RESP_OKAY);
    rd(OFF_LOW_CTRL, 32'hA07A, RESP_OKAY);
    wr(OFF_HIGH_CTRL, 32'hFFFF, RESP_OKAY);
    rd(OFF_HIGH_CTRL, 32'hA072, RESP_OKAY);
    wr(OFF_LOW_CTRL, 32'h0, RESP_OKAY);
    wr(OFF_HIGH_CTRL, 32'h0, RESP_OKAY);
    lfsr = rnd(lfsr);
    wr(OFF_PERIOD_HIGH, lfsr, RESP_OKAY);
    rd(OFF_PERIOD_HIGH, {16'h0, lfsr[15:0]}, RESP_OKAY);
    // every prescale code: 3 * ratio pin edges give exactly three counts
    for (int p = 0; p < 4; p++) begin
      wr(OFF_COUNT_LOW, 32'h0, RESP_OKAY);
      wr(OFF_LOW_CTRL, RUN | EXT | GATE | 32'(p << 4), RESP_OKAY);
      pulses(3 * rt[p], 1'b0);
      wr(OFF_LOW_CTRL, 32'h0, RESP_OKAY);
      rd(OFF_COUNT_LOW, 32'h3, RESP_OKAY);
    end
    // gated: low counts its ten gate cycles, the lone high timer its fifteen
    wr(OFF_COUNT_LOW, 32'h0, RESP_OKAY);
    wr(OFF_COUNT_HIGH, 32'h0, RESP_OKAY);
    wr(OFF_HIGH_CTRL, RUN | GATE, RESP_OKAY);
    wr(OFF_LOW_CTRL, RUN | GATE, RESP_OKAY);
    repeat (5) @(posedge aclk);
    gl <= 1'b1;
    gh <= 1'b1;
    repeat (10) @(posedge aclk);
    gl <= 1'b0;
    repeat (5) @(posedge aclk);
    gh <= 1'b0;
    wr(OFF_LOW_CTRL, 32'h0, RESP_OKAY);
    wr(OFF_HIGH_CTRL, 32'h0, RESP_OKAY);
    rd(OFF_COUNT_LOW, 32'd10, RESP_OKAY);
    rd(OFF_COUNT_HIGH, 32'd15, RESP_OKAY);
    // idle halt drops the first five edges
    wr(OFF_COUNT_LOW, 32'h0, RESP_OKAY);
    idle_mode <= 1'b1;
    wr(OFF_LOW_CTRL, RUN | HALT | EXT, RESP_OKAY);
    pulses(5, 1'b0);
    wr(OFF_LOW_CTRL, RUN | EXT, RESP_OKAY);
    pulses(4, 1'b0);
    idle_mode <= 1'b0;
    wr(OFF_LOW_CTRL, 32'h0, RESP_OKAY);
    rd(OFF_COUNT_LOW, 32'h4, RESP_OKAY);
    // period 3 wraps after the fourth edge and raises the low flag
    wr(OFF_COUNT_LOW, 32'h0, RESP_OKAY);
    wr(OFF_PERIOD_LOW, 32'h3, RESP_OKAY);
    wr(OFF_IRQ_CTRL, 32'h7B, RESP_OKAY);
    wr(OFF_LOW_CTRL, RUN | EXT, RESP_OKAY);
    pulses(6, 1'b0);
    wr(OFF_LOW_CTRL, 32'h0, RESP_OKAY);
    rd(OFF_COUNT_LOW, 32'h2, RESP_OKAY);
    #1 chk("irq_low", 34'h1, {33'h0, irq_low});
    chk("irq_priority", 34'h5, {31'h0, irq_priority});
    wr(OFF_IRQ_FLAGS, 32'h1, RESP_OKAY);
    rd(OFF_IRQ_FLAGS, 32'h0, RESP_OKAY);
    // timer mode counts aclk cycles with no pin activity
    wr(OFF_LOW_CTRL, RUN, RESP_OKAY);
    repeat (20) @(posedge aclk);
    wr(OFF_LOW_CTRL, 32'h0, RESP_OKAY);
    rd(OFF_IRQ_FLAGS, 32'h1, RESP_OKAY);
    wr(OFF_IRQ_FLAGS, 32'h1, RESP_OKAY);
    // paired: carry into the high word, high pin and high run ignored
    wr(OFF_COUNT_LOW, 32'hFFFE, RESP_OKAY);
    wr(OFF_COUNT_HIGH, 32'h0, RESP_OKAY);
    wr(OFF_PERIOD_LOW, 32'hFFFF, RESP_OKAY);
    wr(OFF_PERIOD_HIGH, 32'h1, RESP_OKAY);
    wr(OFF_HIGH_CTRL, RUN | EXT, RESP_OKAY);
    idle_mode <= 1'b1;
    wr(OFF_LOW_CTRL, RUN | HALT | PAIR | EXT, RESP_OKAY);
    pulses(3, 1'b1);
    wr(OFF_HIGH_CTRL, 32'h0, RESP_OKAY);
    wr(OFF_LOW_CTRL, 32'h0, RESP_OKAY);
    rd(OFF_COUNT_HIGH, 32'h1, RESP_OKAY);
    rd(OFF_COUNT_LOW, 32'h1, RESP_OKAY);
    // 32-bit period 0001_0002 wraps on the second edge, high flag only
    wr(OFF_PERIOD_LOW, 32'h2, RESP_OKAY);
    wr(OFF_LOW_CTRL, RUN | PAIR | EXT, RESP_OKAY);
    pulses(2, 1'b0);
    idle_mode <= 1'b0;
    #1 chk("irq_high", 34'h1, {33'h0, irq_high});
    chk("irq_low", 34'h0, {33'h0, irq_low});
    chk("prio", 34'h03, {28'h0, irq_priority, upper_irq_priority});
    @(posedge aclk);
    rd(OFF_IRQ_FLAGS, 32'h2, RESP_OKAY);
    rd(OFF_COUNT_LOW, 32'h0, RESP_OKAY);
    wr(OFF_IRQ_FLAGS, 32'h3, RESP_OKAY);
    repeat (3) @(posedge aclk);
    stop_test();
  end
endmodule // testbench
